// ===== verilog/mfs_pkg.sv
// Functional notes
// - Flag absent sensor, normal mode only, no pin
// - Compensation enable low masks absent-sensor flag
// - Thermal shutdown forces recovery and pin low
// - Clear flags: enable cycling, clear write, select toggle
// - Filter: overcurrent 110ms, pump 10us, supply 5us
// - Input, switch, shutdown faults: 100us from soft start
// - Boost overvoltage, absent 100us; temperature 10us; normal only
// - Enable low keeps device in standby
// - Start: load config, switch on, then boost
// - Host writes allowed only after soft start
// - Recovery turns off switch, boost and sinks
// - Host interface stays available during recovery
// - Sample interface select at start-up
// - Select pin ignored once started
// - Reload stored configuration after enable cycling
// - Pump fault forces recovery; flag survives restart
package mfs_pkg;
    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int BOOST_OC_TIME_MS = 110;
    localparam int LONG_FILT_TIME_US = 100;
    localparam int PUMP_FILT_TIME_US = 10;
    localparam int TEMP_FILT_TIME_US = 10;
    localparam int SUPPLY_FILT_TIME_US = 5;
    localparam int SOFT_START_TIME_US = 2000;
    localparam int BOOST_START_TIME_US = 2000;
    localparam int RECOVERY_TIME_MS = 100;
    // Least times round up to whole cycles
    function automatic int mfs_ns_to_cycles(input int ns);
        mfs_ns_to_cycles = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction

    localparam int BOOST_OC_CYCLES = mfs_ns_to_cycles(BOOST_OC_TIME_MS * 1000000);
    localparam int LONG_FILT_CYCLES = mfs_ns_to_cycles(LONG_FILT_TIME_US * 1000);
    localparam int PUMP_FILT_CYCLES = mfs_ns_to_cycles(PUMP_FILT_TIME_US * 1000);
    localparam int TEMP_FILT_CYCLES = mfs_ns_to_cycles(TEMP_FILT_TIME_US * 1000);
    localparam int SUPPLY_FILT_CYCLES = mfs_ns_to_cycles(SUPPLY_FILT_TIME_US * 1000);
    localparam int SOFT_START_CYCLES = mfs_ns_to_cycles(SOFT_START_TIME_US * 1000);
    localparam int BOOST_START_CYCLES = mfs_ns_to_cycles(BOOST_START_TIME_US * 1000);
    localparam int RECOVERY_CYCLES = mfs_ns_to_cycles(RECOVERY_TIME_MS * 1000000);
    localparam int CNT_W = 22;

    // ----------------------------------------------------------------
    // Fault bit positions and groups
    // ----------------------------------------------------------------
    localparam int NUM_FAULTS = 11;
    localparam int F_BOOST_OC = 0;
    localparam int F_BOOST_OV = 1;
    localparam int F_INPUT_OV = 2;
    localparam int F_INPUT_UV = 3;
    localparam int F_LINE_SW = 4;
    localparam int F_SUPPLY_UV = 5;
    localparam int F_THERMAL = 6;
    localparam int F_PUMP = 7;
    localparam int F_TEMP_HIGH = 8;
    localparam int F_TEMP_LOW = 9;
    localparam int F_ABSENT = 10;
    localparam logic [10:0] ARM_ALWAYS = 11'h020;
    localparam logic [10:0] ARM_SOFT = 11'h05c;
    localparam logic [10:0] ARM_BOOST = 11'h081;
    localparam logic [10:0] ARM_NORMAL = 11'h702;
    localparam logic [10:0] COMP_GATED = 11'h700;
    localparam logic [10:0] RECOVERY_MASK = 11'h0ff;
    localparam logic [10:0] PIN_MASK = 11'h3ff;
    localparam logic [10:0] FLAGS_RESET = 11'h000;

    typedef enum logic [2:0] {
        MFS_STANDBY = 3'b000,
        MFS_LOAD = 3'b001,
        MFS_SOFT = 3'b010,
        MFS_BOOST = 3'b011,
        MFS_NORMAL = 3'b100,
        MFS_RECOVERY = 3'b101
    } mfs_state_t;

    function automatic int mfs_filt_cycles(input int idx, input int boost_oc);
        case (idx)
            F_BOOST_OC: mfs_filt_cycles = boost_oc;
            F_SUPPLY_UV: mfs_filt_cycles = SUPPLY_FILT_CYCLES;
            F_PUMP: mfs_filt_cycles = PUMP_FILT_CYCLES;
            F_TEMP_HIGH, F_TEMP_LOW: mfs_filt_cycles = TEMP_FILT_CYCLES;
            default: mfs_filt_cycles = LONG_FILT_CYCLES;
        endcase
    endfunction
endpackage

// ===== verilog/mfs_filt_if.sv
`timescale 1ns/1ps
interface mfs_filt_if;
    logic cond;
    logic armed;
    logic hit;
    modport filt (input cond, input armed, output hit);
    modport ctrl (output cond, output armed, input hit);
endinterface

// ===== verilog/mfs_filter.sv
`timescale 1ns/1ps
module mfs_filter #(
    parameter int LIMIT = 2
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    mfs_filt_if.filt f
);
    localparam logic [mfs_pkg::CNT_W-1:0] LAST = mfs_pkg::CNT_W'(LIMIT - 1);
    logic [mfs_pkg::CNT_W-1:0] cnt_reg;
    logic [mfs_pkg::CNT_W-1:0] cnt_next;
    logic hit_reg;
    logic hit_next;

    always_comb begin
        cnt_next = '0;
        hit_next = 1'b0;
        if (f.cond && f.armed) begin
            // Saturate so a standing condition keeps reporting
            if (cnt_reg >= LAST) begin
                cnt_next = LAST;
                hit_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_reg <= '0;
            hit_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            hit_reg <= hit_next;
        end
    end

    assign f.hit = hit_reg;

    filt_restart_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !(f.cond && f.armed) |=> cnt_reg == '0 && !hit_reg)
        else $error("filter did not restart");
    filt_time_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(hit_reg) |-> $past(cnt_reg) == LAST && $past(f.cond && f.armed))
        else $error("filter fired before its time");
endmodule // mfs_filter

// ===== verilog/mfs_supervisor.sv
`timescale 1ns/1ps
module mfs_supervisor #(
    parameter int BOOST_OC_CYCLES = mfs_pkg::BOOST_OC_CYCLES,
    parameter int SOFT_START_CYCLES = mfs_pkg::SOFT_START_CYCLES,
    parameter int BOOST_START_CYCLES = mfs_pkg::BOOST_START_CYCLES,
    parameter int RECOVERY_CYCLES = mfs_pkg::RECOVERY_CYCLES
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic chip_enable_pin_i,
    input wire logic interface_select_i,
    input wire logic nvm_load_done_i,
    input wire logic external_thermal_comp_enable_i,
    input wire logic clear_faults_i,
    input wire logic serial_chip_select_n_i,
    input wire logic boost_overcurrent_i,
    input wire logic boost_overvoltage_i,
    input wire logic input_overvoltage_i,
    input wire logic input_undervoltage_i,
    input wire logic line_switch_overcurrent_i,
    input wire logic supply_undervoltage_i,
    input wire logic thermal_shutdown_i,
    input wire logic charge_pump_fault_i,
    input wire logic sensor_temp_high_i,
    input wire logic sensor_temp_low_i,
    input wire logic sensor_absent_i,
    output logic nvm_load_req_o,
    output logic line_switch_en_o,
    output logic boost_en_o,
    output logic sinks_en_o,
    output logic host_if_en_o,
    output logic host_write_en_o,
    output logic spi_select_o,
    output logic [10:0] fault_flags_o,
    output logic [2:0] state_o,
    output logic fault_pin_o,
    output logic fault_pin_oe_n_o
);
    localparam logic [mfs_pkg::CNT_W-1:0] SOFT_LAST = mfs_pkg::CNT_W'(SOFT_START_CYCLES - 1);
    localparam logic [mfs_pkg::CNT_W-1:0] BOOST_LAST = mfs_pkg::CNT_W'(BOOST_START_CYCLES - 1);
    localparam logic [mfs_pkg::CNT_W-1:0] REC_LAST = mfs_pkg::CNT_W'(RECOVERY_CYCLES - 1);

    mfs_pkg::mfs_state_t state_reg;
    mfs_pkg::mfs_state_t state_next;
    logic [mfs_pkg::CNT_W-1:0] seq_cnt_reg;
    logic [mfs_pkg::CNT_W-1:0] seq_cnt_next;
    logic [10:0] flags_reg;
    logic [10:0] flags_next;
    logic spi_sel_reg;
    logic spi_sel_next;
    logic cs_prev_reg;
    logic [10:0] cond;
    logic [10:0] armed;
    logic [10:0] hit;
    logic clear_req;
    logic recover_req;
    logic nvm_req_reg;
    logic line_sw_reg;
    logic boost_reg;
    logic sinks_reg;
    logic host_if_reg;
    logic host_wr_reg;
    logic pin_oe_n_reg;

    // ----------------------------------------------------------------
    // Fault filters
    // ----------------------------------------------------------------
    assign cond = {sensor_absent_i, sensor_temp_low_i, sensor_temp_high_i, charge_pump_fault_i,
                   thermal_shutdown_i, supply_undervoltage_i, line_switch_overcurrent_i,
                   input_undervoltage_i, input_overvoltage_i, boost_overvoltage_i,
                   boost_overcurrent_i};

    always_comb begin
        armed = mfs_pkg::ARM_ALWAYS;
        case (state_reg)
            mfs_pkg::MFS_SOFT: armed = armed | mfs_pkg::ARM_SOFT;
            mfs_pkg::MFS_BOOST: armed = armed | mfs_pkg::ARM_SOFT | mfs_pkg::ARM_BOOST;
            mfs_pkg::MFS_NORMAL: armed = armed | mfs_pkg::ARM_SOFT | mfs_pkg::ARM_BOOST
                                         | mfs_pkg::ARM_NORMAL;
            default: armed = armed;
        endcase
        // Sensor faults mean nothing without the external sensor
        if (!external_thermal_comp_enable_i) begin
            armed = armed & ~mfs_pkg::COMP_GATED;
        end
        if (!chip_enable_pin_i) begin
            armed = '0;
        end
    end

    generate
        for (genvar i = 0; i < mfs_pkg::NUM_FAULTS; i++) begin : g_filt
            mfs_filt_if fi ();
            assign fi.cond = cond[i];
            assign fi.armed = armed[i];
            assign hit[i] = fi.hit;
            mfs_filter #(
                .LIMIT(mfs_pkg::mfs_filt_cycles(i, BOOST_OC_CYCLES))
            ) u_filt (
                .clk_i(clk_i),
                .nrst_i(nrst_i),
                .f(fi.filt)
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // Only active power states can fall into recovery
    assign recover_req = |(hit & mfs_pkg::RECOVERY_MASK)
                         && (state_reg == mfs_pkg::MFS_SOFT || state_reg == mfs_pkg::MFS_BOOST
                             || state_reg == mfs_pkg::MFS_NORMAL);

    always_comb begin
        state_next = state_reg;
        seq_cnt_next = seq_cnt_reg + 1'b1;
        spi_sel_next = spi_sel_reg;
        case (state_reg)
            mfs_pkg::MFS_STANDBY: begin
                seq_cnt_next = '0;
                if (chip_enable_pin_i) begin
                    state_next = mfs_pkg::MFS_LOAD;
                end
            end
            mfs_pkg::MFS_LOAD: begin
                seq_cnt_next = '0;
                spi_sel_next = interface_select_i;
                if (nvm_load_done_i) begin
                    state_next = mfs_pkg::MFS_SOFT;
                end
            end
            mfs_pkg::MFS_SOFT: begin
                if (seq_cnt_reg >= SOFT_LAST) begin
                    state_next = mfs_pkg::MFS_BOOST;
                    seq_cnt_next = '0;
                end
            end
            mfs_pkg::MFS_BOOST: begin
                if (seq_cnt_reg >= BOOST_LAST) begin
                    state_next = mfs_pkg::MFS_NORMAL;
                    seq_cnt_next = '0;
                end
            end
            mfs_pkg::MFS_NORMAL: begin
                seq_cnt_next = '0;
            end
            mfs_pkg::MFS_RECOVERY: begin
                // Restart skips the reload; stored settings are still live
                if (seq_cnt_reg >= REC_LAST) begin
                    state_next = mfs_pkg::MFS_SOFT;
                    seq_cnt_next = '0;
                end
            end
            default: begin
                state_next = mfs_pkg::MFS_STANDBY;
                seq_cnt_next = '0;
            end
        endcase
        if (recover_req) begin
            state_next = mfs_pkg::MFS_RECOVERY;
            seq_cnt_next = '0;
        end
        if (!chip_enable_pin_i) begin
            state_next = mfs_pkg::MFS_STANDBY;
            seq_cnt_next = '0;
        end
    end

    // ----------------------------------------------------------------
    // Fault flags
    // ----------------------------------------------------------------
    assign clear_req = clear_faults_i || (serial_chip_select_n_i && !cs_prev_reg);

    always_comb begin
        // A new hit beats a clear in the same cycle; flags outlive restarts
        flags_next = (flags_reg & ~{11{clear_req}}) | hit;
        if (!chip_enable_pin_i) begin
            flags_next = mfs_pkg::FLAGS_RESET;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= mfs_pkg::MFS_STANDBY;
            seq_cnt_reg <= '0;
            flags_reg <= mfs_pkg::FLAGS_RESET;
            spi_sel_reg <= 1'b0;
            cs_prev_reg <= 1'b1;
            nvm_req_reg <= 1'b0;
            line_sw_reg <= 1'b0;
            boost_reg <= 1'b0;
            sinks_reg <= 1'b0;
            host_if_reg <= 1'b0;
            host_wr_reg <= 1'b0;
            pin_oe_n_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            seq_cnt_reg <= seq_cnt_next;
            flags_reg <= flags_next;
            spi_sel_reg <= spi_sel_next;
            cs_prev_reg <= serial_chip_select_n_i;
            nvm_req_reg <= state_next == mfs_pkg::MFS_LOAD;
            line_sw_reg <= state_next inside {mfs_pkg::MFS_SOFT, mfs_pkg::MFS_BOOST,
                                              mfs_pkg::MFS_NORMAL};
            boost_reg <= state_next inside {mfs_pkg::MFS_BOOST, mfs_pkg::MFS_NORMAL};
            sinks_reg <= state_next == mfs_pkg::MFS_NORMAL;
            host_if_reg <= state_next inside {mfs_pkg::MFS_BOOST, mfs_pkg::MFS_NORMAL,
                                              mfs_pkg::MFS_RECOVERY};
            host_wr_reg <= state_next inside {mfs_pkg::MFS_BOOST, mfs_pkg::MFS_NORMAL,
                                              mfs_pkg::MFS_RECOVERY};
            pin_oe_n_reg <= ~|(flags_next & mfs_pkg::PIN_MASK);
        end
    end

    assign nvm_load_req_o = nvm_req_reg;
    assign line_switch_en_o = line_sw_reg;
    assign boost_en_o = boost_reg;
    assign sinks_en_o = sinks_reg;
    assign host_if_en_o = host_if_reg;
    assign host_write_en_o = host_wr_reg;
    assign spi_select_o = spi_sel_reg;
    assign fault_flags_o = flags_reg;
    assign state_o = state_reg;
    assign fault_pin_o = 1'b0;
    assign fault_pin_oe_n_o = pin_oe_n_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    standby_hold_a: assert property (!chip_enable_pin_i |=>
        state_reg == mfs_pkg::MFS_STANDBY && flags_reg == '0 && !boost_en_o)
        else $error("enable low did not force standby");
    absent_mask_a: assert property ($rose(flags_reg[mfs_pkg::F_ABSENT]) |->
        $past(external_thermal_comp_enable_i) && $past(state_reg) == mfs_pkg::MFS_NORMAL)
        else $error("absent sensor flagged while masked");
    absent_nopin_a: assert property ((flags_reg & mfs_pkg::PIN_MASK) == '0 |->
        fault_pin_oe_n_o)
        else $error("fault pin pulled without a pin fault");
    thermal_rec_a: assert property (chip_enable_pin_i && hit[mfs_pkg::F_THERMAL]
        && state_reg inside {mfs_pkg::MFS_SOFT, mfs_pkg::MFS_BOOST, mfs_pkg::MFS_NORMAL}
        |=> state_reg == mfs_pkg::MFS_RECOVERY && !fault_pin_oe_n_o)
        else $error("thermal shutdown did not enter recovery");
    flag_clear_a: assert property (chip_enable_pin_i && clear_faults_i && hit == '0
        |=> flags_reg == '0 && fault_pin_oe_n_o)
        else $error("clear did not drop flags and pin");
    set_wins_a: assert property (chip_enable_pin_i && hit[mfs_pkg::F_PUMP]
        |=> flags_reg[mfs_pkg::F_PUMP] ##1 (flags_reg[mfs_pkg::F_PUMP] || $past(clear_req)
        || !$past(chip_enable_pin_i)))
        else $error("pump fault flag lost");
    rec_off_a: assert property (state_reg == mfs_pkg::MFS_RECOVERY |->
        !line_switch_en_o && !boost_en_o && !sinks_en_o && host_if_en_o)
        else $error("recovery outputs wrong");
    host_write_a: assert property (host_write_en_o |->
        state_reg inside {mfs_pkg::MFS_BOOST, mfs_pkg::MFS_NORMAL, mfs_pkg::MFS_RECOVERY})
        else $error("host write before soft start ended");
    if_hold_a: assert property (state_reg != mfs_pkg::MFS_LOAD |=>
        $stable(spi_select_o))
        else $error("interface select changed after start-up");
    startup_a: assert property ($rose(chip_enable_pin_i)
        && state_reg == mfs_pkg::MFS_STANDBY
        |=> state_reg == mfs_pkg::MFS_LOAD && nvm_load_req_o && !line_switch_en_o)
        else $error("start-up did not request config load");
    soft_a: assert property (state_reg == mfs_pkg::MFS_SOFT |->
        line_switch_en_o && !boost_en_o)
        else $error("soft start outputs wrong");

    rec_entry_c: cover property (state_reg == mfs_pkg::MFS_NORMAL ##1
        state_reg == mfs_pkg::MFS_RECOVERY);
    restart_c: cover property (state_reg == mfs_pkg::MFS_RECOVERY ##1
        state_reg == mfs_pkg::MFS_SOFT);
    cs_clear_c: cover property (flags_reg != '0 ##1 flags_reg == '0 && chip_enable_pin_i);
    normal_c: cover property (state_reg == mfs_pkg::MFS_NORMAL && flags_reg[mfs_pkg::F_ABSENT]);
endmodule // mfs_supervisor

// ===== verif/mfs_nvm_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Stored configuration memory answering load requests
// ----------------------------------------------------------------
module mfs_nvm_model (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic slow_i,
    input wire logic load_req_i,
    output logic load_done_o
);
    logic [3:0] wait_reg;
    // Done only while a request stands, so a dropped request never sees a stale done
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wait_reg <= 4'h0;
            load_done_o <= 1'b0;
        end else if (!load_req_i) begin
            wait_reg <= 4'h0;
            load_done_o <= 1'b0;
        end else begin
            wait_reg <= wait_reg + 4'h1;
            load_done_o <= (wait_reg >= (slow_i ? 4'h8 : 4'h1));
        end
    end
endmodule // mfs_nvm_model

// ===== verif/mode_fault_supervisor_bench.sv
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("[FAIL] t=%0t %s", $time, msg); \
    end \
end
module mode_fault_supervisor_bench;
    localparam int BOC = 50;
    localparam int SSC = 20;
    localparam int BSC = 20;
    localparam int RCC = 30;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic en = 1'b0;
    logic sel = 1'b0;
    logic clr = 1'b0;
    logic cs_n = 1'b1;
    logic comp = 1'b0;
    logic slow = 1'b0;
    logic [10:0] cond = 11'h000;
    logic load_req, load_done, line_sw, boost_en, sinks, host_if, host_we, spi_sel, fpin, oe_n;
    logic [10:0] flags;
    logic [2:0] st;
    int error_cnt = 0;
    int total_checks = 0;

    always #25 clk_i = ~clk_i;

    mfs_nvm_model nvm (.clk_i(clk_i), .nrst_i(nrst_i), .slow_i(slow), .load_req_i(load_req),
        .load_done_o(load_done));

    mfs_supervisor #(.BOOST_OC_CYCLES(BOC), .SOFT_START_CYCLES(SSC),
        .BOOST_START_CYCLES(BSC), .RECOVERY_CYCLES(RCC)) dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .chip_enable_pin_i(en), .interface_select_i(sel),
        .nvm_load_done_i(load_done), .external_thermal_comp_enable_i(comp),
        .clear_faults_i(clr), .serial_chip_select_n_i(cs_n),
        .boost_overcurrent_i(cond[0]), .boost_overvoltage_i(cond[1]),
        .input_overvoltage_i(cond[2]), .input_undervoltage_i(cond[3]),
        .line_switch_overcurrent_i(cond[4]), .supply_undervoltage_i(cond[5]),
        .thermal_shutdown_i(cond[6]), .charge_pump_fault_i(cond[7]),
        .sensor_temp_high_i(cond[8]), .sensor_temp_low_i(cond[9]), .sensor_absent_i(cond[10]),
        .nvm_load_req_o(load_req), .line_switch_en_o(line_sw), .boost_en_o(boost_en),
        .sinks_en_o(sinks), .host_if_en_o(host_if), .host_write_en_o(host_we),
        .spi_select_o(spi_sel), .fault_flags_o(flags), .state_o(st), .fault_pin_o(fpin),
        .fault_pin_oe_n_o(oe_n));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #5;
    endtask

    task automatic wait_state(input mfs_pkg::mfs_state_t s, input int lim);
        int k;
        k = 0;
        while (st !== s && k < lim) begin
            tick(1);
            k++;
        end
        `CHK(st, s, "state not reached")
    endtask

    task automatic start_up(input logic s);
        sel = s;
        en = 1'b1;
        wait_state(mfs_pkg::MFS_LOAD, 2);
        `CHK(load_req, 1'b1, "no configuration load")
        wait_state(mfs_pkg::MFS_SOFT, 12);
        `CHK({line_sw, boost_en, host_we, load_req}, 4'h8, "soft start")
        wait_state(mfs_pkg::MFS_BOOST, SSC + 4);
        `CHK({boost_en, host_if, host_we, sinks}, 4'he, "boost start")
        wait_state(mfs_pkg::MFS_NORMAL, BSC + 4);
        `CHK(sinks, 1'b1, "sinks off in normal mode")
        `CHK(spi_sel, s, "interface select")
        sel = ~s;
        tick(3);
        `CHK(spi_sel, s, "select followed in normal mode")
    endtask

    // Glitch first, then a full hold; the count is from the first sampling edge
    task automatic fault_case(input int i);
        int lim;
        int n;
        mfs_pkg::mfs_state_t exp_st;
        lim = (i == 0) ? BOC : (i == 5) ? mfs_pkg::SUPPLY_FILT_CYCLES :
            (i == 7) ? mfs_pkg::PUMP_FILT_CYCLES :
            (i == 8 || i == 9) ? mfs_pkg::TEMP_FILT_CYCLES : mfs_pkg::LONG_FILT_CYCLES;
        cond[i] = 1'b1;
        tick(lim - 1);
        cond[i] = 1'b0;
        tick(1);
        cond[i] = 1'b1;
        tick(lim - 1);
        `CHK(flags, 11'h000, "flag before filter time")
        n = lim - 1;
        while (flags[i] !== 1'b1 && n < lim + 4) begin
            tick(1);
            n++;
        end
        `CHK(n, lim + 1, "filter time")
        `CHK(flags, 11'(1 << i), "flag pattern")
        `CHK(oe_n, (i < 10) ? 1'b0 : 1'b1, "fault pin")
        exp_st = (i < 8) ? mfs_pkg::MFS_RECOVERY : mfs_pkg::MFS_NORMAL;
        `CHK(st, exp_st, "recovery entry")
        if (i < 8) begin
            `CHK({line_sw, boost_en, sinks, host_if}, 4'h1, "outputs off")
        end
        cond[i] = 1'b0;
        // Let the standing hit drain first, or it beats the clear below
        tick(1);
        if (i < 8) begin
            wait_state(mfs_pkg::MFS_NORMAL, RCC + SSC + BSC + 10);
            `CHK(flags[i], 1'b1, "flag lost after restart")
        end
        if (i % 2 == 1) begin
            clr = 1'b1;
            tick(1);
            clr = 1'b0;
            tick(1);
        end else begin
            cs_n = 1'b0;
            tick(1);
            cs_n = 1'b1;
            tick(2);
        end
        `CHK({flags, oe_n}, 12'h001, "flags not cleared")
    endtask

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        tick(12);
        nrst_i = 1'b1;
        tick(5);
        `CHK({st, load_req, line_sw, oe_n, fpin}, 7'h02, "standby after reset")
        start_up(1'b1);
        comp = 1'b1;
        for (int i = 0; i < 11; i++) begin
            fault_case(i);
        end
        comp = 1'b0;
        cond[10] = 1'b1;
        tick(mfs_pkg::LONG_FILT_CYCLES + 50);
        `CHK(flags, 11'h000, "absent sensor not masked")
        cond[10] = 1'b0;
        comp = 1'b1;
        cond[9] = 1'b1;
        tick(mfs_pkg::TEMP_FILT_CYCLES + 3);
        `CHK(flags[9], 1'b1, "temperature flag")
        en = 1'b0;
        tick(2);
        `CHK({st, flags, oe_n, line_sw}, 16'h0002, "enable low reset")
        tick(3);
        `CHK(flags, 11'h000, "standing fault flagged in standby")
        cond[9] = 1'b0;
        tick(5);
        `CHK(st, mfs_pkg::MFS_STANDBY, "left standby")
        slow = 1'b1;
        start_up(1'b0);
        conclude();
    end

    initial begin
        #3000000;
        error_cnt++;
        $display("[FAIL] t=%0t watchdog expired", $time);
        conclude();
    end
endmodule // mode_fault_supervisor_bench
